// File: verilog/pdct_pkg.sv
// constants and types for the prescaled down counter timer
package pdct_pkg;
   localparam logic [7:0] PDCT_ADDR_PRESC  = 8'hD2;
   localparam logic [7:0] PDCT_ADDR_COUNT  = 8'hD3;
   localparam logic [7:0] PDCT_ADDR_CTRL   = 8'hD4;
   localparam int         PDCT_ZERO_BIT    = 7;
   localparam int         PDCT_IEN_BIT     = 6;
   localparam int         PDCT_DIR_BIT     = 5;
   localparam int         PDCT_DATA_BIT    = 4;
   localparam int         PDCT_RUN_BIT     = 3;
   localparam logic [7:0] PDCT_COUNT_RESET = 8'hFF;
   localparam logic [6:0] PDCT_PRESC_RESET = 7'h7F;
   localparam logic [7:0] PDCT_CTRL_RESET  = 8'h00;
   localparam int         PDCT_INT_DIV     = 12;
   localparam logic [3:0] PDCT_DIV_LAST    = 4'(PDCT_INT_DIV - 1);
   localparam logic [7:0] PDCT_IRQ_VECTOR  = 8'h04;
   typedef enum logic [1:0] {
      PDCT_MODE_EVENT = 2'b00,
      PDCT_MODE_GATED = 2'b01,
      PDCT_MODE_OUT0  = 2'b10,
      PDCT_MODE_OUT1  = 2'b11
   } pdct_mode_t;
endpackage

// File: verilog/pdct_timer.sv
// prescaled eight-bit down counter timer with timer pin modes
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - count decrements on tap edge; zero sets flag
// - irq while zero flag and enable set
// - prescaler fed by clock/12 or pin
// - tap k-1 clocks count; factor one direct
// - tap select maps to powers of two
// - run bit low forces 7Fh, stops prescaler and count
// - software may load prescaler while running
// - gated mode counts clock/12 while pin high
// - event mode counts pin rising edges
// - output mode drives pin from latch
// - latch transparent while zero flag high
// - write 00h or bit7 sets zero flag
// - reset loads FFh, 7Fh, clears control
// - count write beats coincident zero decrement
// - count and prescaler read back live
// - control fields at D4h as documented
// - pending irq offered as wake request
// - direction high forces pin as output
module pdct_timer (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [7:0]  reg_rdata,
   // timer pin
   input  wire logic        timer_pin_in,
   output logic             timer_pin_out,
   output logic             timer_pin_oe,
   output logic             port_override,
   // interrupt
   output logic             irq_request,
   output logic      [7:0]  irq_vector,
   output logic             wake_request
);
   import pdct_pkg::*;

   typedef struct packed {
      logic [7:0] count_value;
      logic [6:0] prescaler_value;
      logic       zero_flag;
      logic       zero_irq_enable;
      logic       pin_direction_select;
      logic       pin_data;
      logic       prescaler_run;
      logic [2:0] tap_select;
      logic [3:0] div_cnt;
      logic       pin_s1;
      logic       pin_s2;
      logic       pin_s3;
      logic       out_latch;
      logic [7:0] rdata;
   } pdct_state_t;

   pdct_state_t st;
   pdct_state_t next_st;

   // rising edge test for the synchronised pin
   function automatic logic rose(input logic now_v, input logic was_v);
      rose = now_v & ~was_v;
   endfunction

   // a borrow reaches bit k-1 only when the k low bits are all zero,
   // so the tap rises on the input tick itself; no stale edge memory
   function automatic logic tap_borrow(input logic [6:0] value, input logic [2:0] tap);
      logic [6:0] mask;
      mask = 7'((8'h01 << tap) - 8'h01);
      tap_borrow = ((value & mask) == 7'h00);
   endfunction

   logic       div_tick;
   logic       presc_tick;
   logic       count_tick;
   logic [7:0] count_dec;
   logic       wr_presc;
   logic       wr_count;
   logic       wr_ctrl;
   pdct_mode_t mode;

   always_comb begin
      next_st = st;
      mode = pdct_mode_t'({st.pin_direction_select, st.pin_data});
      wr_presc = reg_write && (reg_addr == PDCT_ADDR_PRESC);
      wr_count = reg_write && (reg_addr == PDCT_ADDR_COUNT);
      wr_ctrl  = reg_write && (reg_addr == PDCT_ADDR_CTRL);
      // pin synchroniser; s1 feeds only s2
      next_st.pin_s1 = timer_pin_in;
      next_st.pin_s2 = st.pin_s1;
      next_st.pin_s3 = st.pin_s2;
      // internal divide by twelve
      div_tick = (st.div_cnt == PDCT_DIV_LAST);
      next_st.div_cnt = div_tick ? 4'h0 : st.div_cnt + 4'h1;
      // prescaler clock source per mode
      case (mode)
         PDCT_MODE_EVENT: presc_tick = rose(st.pin_s2, st.pin_s3);
         PDCT_MODE_GATED: presc_tick = div_tick && st.pin_s2;
         PDCT_MODE_OUT0,
         PDCT_MODE_OUT1:  presc_tick = div_tick;
         default:         presc_tick = 1'b0;
      endcase
      presc_tick = presc_tick && st.prescaler_run;
      // tap: factor one uses input, else rising bit k-1
      // a prescaler load replaces the decrement, so no tap edge then except at factor one
      count_tick = presc_tick
                   && ((st.tap_select == 3'h0) || !wr_presc)
                   && tap_borrow(st.prescaler_value, st.tap_select);
      // prescaler update
      if (!st.prescaler_run) begin
         next_st.prescaler_value = PDCT_PRESC_RESET;
      end else if (wr_presc) begin
         next_st.prescaler_value = reg_wdata[6:0];
      end else if (presc_tick) begin
         next_st.prescaler_value = st.prescaler_value - 7'h01;
      end
      // count update; write wins over decrement
      count_dec = st.count_value - 8'h01;
      if (wr_count) begin
         next_st.count_value = reg_wdata;
         if (reg_wdata == 8'h00) begin
            next_st.zero_flag = 1'b1;
         end
      end else if (count_tick) begin
         next_st.count_value = count_dec;
      end
      // control write; hardware set wins over software clear
      if (wr_ctrl) begin
         next_st.zero_flag            = reg_wdata[PDCT_ZERO_BIT];
         next_st.zero_irq_enable      = reg_wdata[PDCT_IEN_BIT];
         next_st.pin_direction_select = reg_wdata[PDCT_DIR_BIT];
         next_st.pin_data             = reg_wdata[PDCT_DATA_BIT];
         next_st.prescaler_run        = reg_wdata[PDCT_RUN_BIT];
         next_st.tap_select           = reg_wdata[2:0];
         if (wr_count && reg_wdata == 8'h00) begin
            next_st.zero_flag = 1'b1;
         end
      end
      if (!wr_count && count_tick && count_dec == 8'h00) begin
         next_st.zero_flag = 1'b1;
      end
      // output latch follows data while flag high
      if (st.zero_flag) begin
         next_st.out_latch = st.pin_data;
      end
      // live read back, one cycle later
      next_st.rdata = 8'h00;
      if (reg_read) begin
         case (reg_addr)
            PDCT_ADDR_PRESC: next_st.rdata = {1'b0, st.prescaler_value};
            PDCT_ADDR_COUNT: next_st.rdata = st.count_value;
            PDCT_ADDR_CTRL:  next_st.rdata = {st.zero_flag, st.zero_irq_enable,
                                              st.pin_direction_select, st.pin_data,
                                              st.prescaler_run, st.tap_select};
            default:         next_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st                 <= '0;
         st.count_value     <= PDCT_COUNT_RESET;
         st.prescaler_value <= PDCT_PRESC_RESET;
         {st.zero_flag, st.zero_irq_enable, st.pin_direction_select, st.pin_data,
          st.prescaler_run, st.tap_select} <= PDCT_CTRL_RESET;
      end else begin
         st <= next_st;
      end
   end

   // transparent while flag high, so no cycle of lag on the pin
   assign timer_pin_out = st.zero_flag ? st.pin_data : st.out_latch;
   assign timer_pin_oe  = st.pin_direction_select;
   assign port_override = st.pin_direction_select;
   assign irq_request   = st.zero_flag && st.zero_irq_enable;
   assign irq_vector    = PDCT_IRQ_VECTOR;
   assign wake_request  = irq_request;
   assign reg_rdata     = st.rdata;

endmodule // pdct_timer
`default_nettype wire

// File: test/pdct_timer_checker.sv
// port assertions for the timer
`timescale 1ns/1ps
`default_nettype none
module pdct_timer_checker (
   // clock, reset, register port
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   // pin and interrupt
   input wire logic       timer_pin_out,
   input wire logic       timer_pin_oe,
   input wire logic       port_override,
   input wire logic       irq_request,
   input wire logic [7:0] irq_vector,
   input wire logic       wake_request
);
   import pdct_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_cw;
      reg_write && reg_addr == PDCT_ADDR_CTRL;
   endsequence
   a_dir_oe: assert property (s_cw |=> timer_pin_oe == $past(reg_wdata[5]))
      else $error("oe mismatch");
   a_port_override: assert property (port_override == timer_pin_oe)
      else $error("override mismatch");
   a_irq_vector: assert property (irq_request |-> irq_vector == PDCT_IRQ_VECTOR)
      else $error("bad vector");
   a_wake_irq: assert property (wake_request == irq_request)
      else $error("wake mismatch");
   a_irq_masked: assert property (s_cw ##0 !reg_wdata[6] |=> !irq_request)
      else $error("irq while masked");
   a_irq_raise: assert property (s_cw ##0 reg_wdata[7:6] == 2'b11 |=> irq_request)
      else $error("irq missing");
   a_out_copy: assert property (s_cw ##0 reg_wdata[7] |=> timer_pin_out == $past(reg_wdata[4]))
      else $error("pin not copied");
   a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("rdata not idle");
   a_presc_msb: assert property (reg_read && reg_addr == PDCT_ADDR_PRESC |=> !reg_rdata[7])
      else $error("prescaler msb set");
endmodule // pdct_timer_checker
bind pdct_timer pdct_timer_checker chk (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write,
   .reg_read, .reg_rdata, .timer_pin_out, .timer_pin_oe, .port_override, .irq_request,
   .irq_vector, .wake_request);
`default_nettype wire

// File: test/pdct_pin_model.sv
// far side of the timer pin: signal source or load
`timescale 1ns/1ps
`default_nettype none
module pdct_pin_model (
   input  wire logic drive_level,
   input  wire logic timer_pin_oe,
   input  wire logic timer_pin_out,
   output logic      pin_level
);
   // source lets go while the device drives the wire
   assign pin_level = timer_pin_oe ? timer_pin_out : drive_level;
endmodule // pdct_pin_model
`default_nettype wire

// File: test/pdct_timer_tb.sv
// self-checking bench for the timer
`timescale 1ns/1ps
`default_nettype none
module pdct_timer_tb;
   import pdct_pkg::*;
   logic       clk = 0, sys_rst = 1, reg_write = 0, reg_read = 0, drive_level = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, irq_vector, v;
   logic       timer_pin_out, timer_pin_oe, port_override, irq_request, wake_request, pin_level;
   int         miscompares = 0, comparisons = 0, cycles = 0;
   // address, write data, read back
   logic [23:0] rows [4] = '{24'hD4_07_07, 24'hD3_5A_5A, 24'hD2_33_7F, 24'hD4_17_17};
   always #25 clk = ~clk;
   pdct_timer uut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .timer_pin_in(pin_level), .timer_pin_out, .timer_pin_oe, .port_override, .irq_request,
      .irq_vector, .wake_request);
   pdct_pin_model pin (.drive_level, .timer_pin_oe, .timer_pin_out, .pin_level);
   task automatic conclude;
      if (miscompares == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares = miscompares + 1;
         conclude();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
      @(posedge clk) reg_write <= 0;
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input bit c = 1);
      @(posedge clk) {reg_addr, reg_read} <= {a, 1'b1};
      @(posedge clk) reg_read <= 0;
      #1 v = reg_rdata;
      if (c) chk(v, e);
   endtask
   // pin held in each phase well past the two synchroniser stages
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk) drive_level <= 1;
         repeat (4) @(posedge clk);
         drive_level <= 0;
         repeat (4) @(posedge clk);
      end
      repeat (6) @(posedge clk);
   endtask
   task automatic poll(input logic [7:0] want);
      for (int i = 0; i < 40 && v !== want; i++) rdc(PDCT_ADDR_COUNT, 0, 0);
      chk(v, want);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 0;
      rdc(PDCT_ADDR_COUNT, 8'hFF);
      rdc(PDCT_ADDR_PRESC, 8'h7F);
      rdc(PDCT_ADDR_CTRL, 8'h00);
      rdc(8'hD5, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rdc(rows[i][23:16], rows[i][7:0]);
      end
      wr(PDCT_ADDR_COUNT, 8'h00);
      rdc(PDCT_ADDR_CTRL, 8'h97);
      wr(PDCT_ADDR_CTRL, 8'hC0);
      chk(irq_request, 1);
      wr(PDCT_ADDR_CTRL, 8'h80);
      chk(irq_request, 0);
      wr(PDCT_ADDR_CTRL, 8'h00);
      wr(PDCT_ADDR_COUNT, 8'h05);
      wr(PDCT_ADDR_CTRL, 8'h08);
      pulse(3);
      rdc(PDCT_ADDR_COUNT, 8'h02);
      wr(PDCT_ADDR_CTRL, 8'h00);
      wr(PDCT_ADDR_COUNT, 8'h05);
      wr(PDCT_ADDR_CTRL, 8'h09);
      pulse(4);
      rdc(PDCT_ADDR_COUNT, 8'h03);
      rdc(PDCT_ADDR_PRESC, 8'h7B);
      wr(PDCT_ADDR_PRESC, 8'h40);
      rdc(PDCT_ADDR_PRESC, 8'h40);
      wr(PDCT_ADDR_CTRL, 8'h01);
      pulse(2);
      rdc(PDCT_ADDR_PRESC, 8'h7F);
      rdc(PDCT_ADDR_COUNT, 8'h03);
      wr(PDCT_ADDR_COUNT, 8'h0A);
      wr(PDCT_ADDR_CTRL, 8'h18);
      repeat (60) @(posedge clk);
      rdc(PDCT_ADDR_COUNT, 8'h0A);
      @(posedge clk) drive_level <= 1;
      repeat (48) @(posedge clk);
      drive_level <= 0;
      repeat (6) @(posedge clk);
      rdc(PDCT_ADDR_COUNT, 8'h06);
      wr(PDCT_ADDR_CTRL, 8'h00);
      wr(PDCT_ADDR_COUNT, 8'h03);
      wr(PDCT_ADDR_CTRL, 8'h28);
      poll(8'h00);
      rdc(PDCT_ADDR_CTRL, 8'hA8);
      poll(8'hFF);
      wr(PDCT_ADDR_CTRL, 8'hB0);
      chk(pin_level, 1);
      wr(PDCT_ADDR_CTRL, 8'h20);
      chk(pin_level, 1);
      conclude();
   end
endmodule // pdct_timer_tb
`default_nettype wire
